//--- core/cbw_pkg.sv
/*
 Package for the cache bus-watch control block: register offsets, control
 field layout, reset values, system tag codes, cycle-type decoding, carriers.
 Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock.
*/
// Behaviour
// - Own write to tag-6 page purges own hit lines and still writes with tag 6.
// - With cpu-write watch on, observed tag-6 bus write purges hit lines.
// - Slave I/O read issues ordinary memory read tagged 7, data may be dropped.
// - Slave I/O write is a memory write tagged 7, no own data driven.
// - On slave I/O write, direction turns to read right after address phase.
// - With any watch enabled, classify other masters' accesses by tag and cycle type.
// - Cpu-write watch: shared write hit updates single word, invalidates quadword.
// - I/O-write watch: cacheable write hit updates single word, invalidates quadword.
// - I/O-read watch: copy-back read miss or clean hit stays passive.
// - Dirty hit on such read suppresses memory and supplies cached data.
// - With clear-valid set, the supplying dirty line loses its valid flag.
// - Clear-valid is bit 8, reset clear; bits 7:6 and 31:9 read zero.
// - Unmapped tag: 0 private WT, 1 shared WT, 2 private CB, 3 noncacheable.
// - Unmapped addresses drive unmapped tag on tag 1:0, tag bit 2 zero, except supervisor ones up to 0x7FFF, which keep the page tag.
// - Bits 3,2,1 enable io-read, io-write, cpu-write watch; all set at reset; bit 3 has no effect unless DATA_SIDE is set.
// - Bit 0 enables prefetch, set at reset; data-side unit ignores it.
// - Flag-clear register bits 6..0 clear used, ref, dirty, uv, sv, lvx, lvw.
// - Page fault captures faulting virtual address in read-only fault register.
package cbw_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_SUP_PDB = 8'h00;
   localparam logic [7:0] OFF_USR_PDB = 8'h04;
   localparam logic [7:0] OFF_FAULT = 8'h08;
   localparam logic [7:0] OFF_CTRL = 8'h0C;
   localparam logic [7:0] OFF_FLAG_CLR = 8'h10;
   // Control register fields
   localparam int CTL_PREFETCH = 0;
   localparam int CTL_WATCH_CPU_WR = 1;
   localparam int CTL_WATCH_IO_WR = 2;
   localparam int CTL_WATCH_IO_RD = 3;
   localparam int CTL_UTAG_LO = 4;
   localparam int CTL_CLEAR_VALID = 8;
   localparam logic [8:0] CTL_WRITE_MASK = 9'h13F;
   localparam logic [8:0] CTL_RESET = 9'h03F;
   localparam logic [6:0] FLAG_CLR_MASK = 7'h7F;
   localparam logic [19:0] PDB_RESET = 20'h00000;
   // System tags
   localparam logic [2:0] TAG_PURGE = 3'h6;
   localparam logic [2:0] TAG_SLAVE_IO = 3'h7;
   localparam logic [1:0] UTAG_PRIV_WT = 2'h0;
   localparam logic [1:0] UTAG_SHARED_WT = 2'h1;
   localparam logic [1:0] UTAG_PRIV_CB = 2'h2;
   localparam logic [1:0] UTAG_NONCACHE = 2'h3;
   localparam logic [31:0] FIXED_TRANSLATION_BUFFER_LIMIT = 32'h00007FFF;
   // Cycle type decoding: [5] master is I/O, [4] write, [3] quadword
   localparam int CT_IO = 5;
   localparam int CT_WR = 4;
   localparam int CT_QUAD = 3;

   typedef enum logic [2:0] {
      CBW_IDLE = 3'b000,
      CBW_ADDR = 3'b001,
      CBW_DATA = 3'b010,
      CBW_DONE = 3'b011
   } cbw_bus_state_type;

   typedef enum logic [1:0] {
      CBW_ACT_NONE = 2'b00,
      CBW_ACT_UPDATE = 2'b01,
      CBW_ACT_INVALIDATE = 2'b10,
      CBW_ACT_SUPPLY = 2'b11
   } cbw_action_type;

   // Observed bus cycle from the snoop port
   typedef struct packed {
      logic valid;
      logic [2:0] tag;
      logic [5:0] cycle_type;
      logic hit;
      logic dirty;
   } cbw_snoop_type;

   // Local processor request
   typedef struct packed {
      logic valid;
      logic write;
      logic mapped;
      logic supervisor;
      logic [2:0] page_tag;
      logic [31:0] addr;
   } cbw_cpu_req_type;

   // Action to the cache array
   typedef struct packed {
      cbw_action_type act;
      logic clear_valid;
   } cbw_cache_cmd_type;
endpackage

//--- core/cbw_top.sv
/*
 Cache bus-watch control: AXI4-Lite registers, own bus cycle tagging,
 slave I/O direction control and snoop classification.
 Assumes synchronous snoop and cpu inputs on clk; bus pins pre-synchronised
 except bus_ready_input, which is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module cbw_top
   import cbw_pkg::*;
#(
   parameter bit DATA_SIDE = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Local processor side
   input wire cbw_cpu_req_type cpu_req,
   output logic cpu_busy,
   input wire logic page_fault,
   input wire logic [31:0] fault_vaddr,
   // System bus
   output logic [2:0] system_tag_lines,
   output logic bus_request,
   output logic bus_write,
   output logic bus_dir_read,
   output logic bus_data_oe,
   input wire logic bus_ready_input,
   // Snoop
   input wire cbw_snoop_type snoop,
   output logic memory_inhibit,
   output cbw_cache_cmd_type cache_cmd,
   // Own-cycle purge of own hit lines
   output logic own_purge,
   // Control outputs
   output logic prefetch_enable,
   output logic [6:0] flag_clear,
   output logic [19:0] sup_pdb,
   output logic [19:0] usr_pdb
);

   //----------------------------------------------------------------
   // State
   //----------------------------------------------------------------
   typedef struct packed {
      logic aw_hold;
      logic [7:0] aw_addr;
      logic w_hold;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] bresp;
      logic [1:0] rresp;
      logic [19:0] sup_pdb;
      logic [19:0] usr_pdb;
      logic [31:0] fault_address;
      logic [8:0] ctrl;
      logic [6:0] flag_clear;
      cbw_bus_state_type bstate;
      logic [2:0] tag;
      logic wr;
      logic slave_io;
      logic dir_read;
      logic data_oe;
      logic purge;
      logic rdy_s1;
      logic rdy_s2;
      cbw_cache_cmd_type cmd;
      logic inhibit;
   } cbw_state_type;

   cbw_state_type st_ff;
   cbw_state_type nxt_st;

   function automatic logic [31:0] merge_strb(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic known_offset(input logic [7:0] a);
      return a == OFF_SUP_PDB || a == OFF_USR_PDB || a == OFF_FAULT ||
         a == OFF_CTRL || a == OFF_FLAG_CLR;
   endfunction

   logic wr_fire;
   logic rd_fire;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [31:0] merged;
   logic [2:0] own_tag;
   logic unmapped;
   cbw_action_type act;
   logic watch_cpu;
   logic watch_io_wr;
   logic watch_io_rd;

   always_comb begin
      nxt_st = st_ff;
      wa = 8'h00;
      wd = 32'h00000000;
      merged = 32'h00000000;
      own_tag = 3'h0;
      unmapped = 1'b0;
      act = CBW_ACT_NONE;
      watch_cpu = st_ff.ctrl[CTL_WATCH_CPU_WR];
      watch_io_wr = st_ff.ctrl[CTL_WATCH_IO_WR];
      watch_io_rd = st_ff.ctrl[CTL_WATCH_IO_RD] & DATA_SIDE;

      //----------------------------------------------------------------
      // AXI4-Lite write
      //----------------------------------------------------------------
      nxt_st.flag_clear = 7'h00;
      if (s_axi_awvalid && !st_ff.aw_hold) begin
         nxt_st.aw_hold = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_ff.w_hold) begin
         nxt_st.w_hold = 1'b1;
         nxt_st.w_data = s_axi_wdata;
         nxt_st.w_strb = s_axi_wstrb;
      end
      wr_fire = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;
      wa = {st_ff.aw_addr[7:2], 2'b00};
      wd = st_ff.w_data;
      if (wr_fire) begin
         nxt_st.aw_hold = 1'b0;
         nxt_st.w_hold = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = known_offset(wa) && wa != OFF_FAULT ? 2'b00 : 2'b10;
         case (wa)
            OFF_SUP_PDB: begin
               merged = merge_strb({12'h000, st_ff.sup_pdb}, wd, st_ff.w_strb);
               nxt_st.sup_pdb = merged[19:0];
            end
            OFF_USR_PDB: begin
               merged = merge_strb({12'h000, st_ff.usr_pdb}, wd, st_ff.w_strb);
               nxt_st.usr_pdb = merged[19:0];
            end
            OFF_CTRL: begin
               merged = merge_strb({23'h000000, st_ff.ctrl}, wd, st_ff.w_strb);
               nxt_st.ctrl = merged[8:0] & CTL_WRITE_MASK;
            end
            OFF_FLAG_CLR: begin
               if (st_ff.w_strb[0]) begin
                  nxt_st.flag_clear = wd[6:0] & FLAG_CLR_MASK;
               end
            end
            default: begin
            end
         endcase
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      //----------------------------------------------------------------
      // AXI4-Lite read
      //----------------------------------------------------------------
      rd_fire = s_axi_arvalid && !st_ff.rvalid;
      if (rd_fire) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = known_offset({s_axi_araddr[7:2], 2'b00}) ? 2'b00 : 2'b10;
         case ({s_axi_araddr[7:2], 2'b00})
            OFF_SUP_PDB: nxt_st.rdata = {12'h000, st_ff.sup_pdb};
            OFF_USR_PDB: nxt_st.rdata = {12'h000, st_ff.usr_pdb};
            OFF_FAULT: nxt_st.rdata = st_ff.fault_address;
            OFF_CTRL: nxt_st.rdata = {23'h000000, st_ff.ctrl};
            default: nxt_st.rdata = 32'h00000000;
         endcase
      end else if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end

      //----------------------------------------------------------------
      // Fault capture
      //----------------------------------------------------------------
      if (page_fault) begin
         nxt_st.fault_address = fault_vaddr;
      end

      //----------------------------------------------------------------
      // Own bus cycle
      //----------------------------------------------------------------
      unmapped = !cpu_req.mapped &&
         !(cpu_req.supervisor && cpu_req.addr <= FIXED_TRANSLATION_BUFFER_LIMIT);
      own_tag = unmapped ? {1'b0, st_ff.ctrl[CTL_UTAG_LO +: 2]} :
         cpu_req.page_tag;
      nxt_st.rdy_s1 = bus_ready_input;
      nxt_st.rdy_s2 = st_ff.rdy_s1;
      nxt_st.purge = 1'b0;
      case (st_ff.bstate)
         CBW_IDLE: begin
            if (cpu_req.valid) begin
               nxt_st.bstate = CBW_ADDR;
               nxt_st.tag = own_tag;
               nxt_st.wr = cpu_req.write;
               nxt_st.slave_io = own_tag == TAG_SLAVE_IO;
               nxt_st.dir_read = !cpu_req.write;
               nxt_st.data_oe = 1'b0;
               nxt_st.purge = cpu_req.write && own_tag == TAG_PURGE;
            end
         end
         CBW_ADDR: begin
            nxt_st.bstate = CBW_DATA;
            if (st_ff.wr && st_ff.slave_io) begin
               nxt_st.dir_read = 1'b1;
               nxt_st.data_oe = 1'b0;
            end else begin
               nxt_st.data_oe = st_ff.wr;
            end
         end
         CBW_DATA: begin
            if (st_ff.rdy_s2) begin
               nxt_st.bstate = CBW_DONE;
               nxt_st.data_oe = 1'b0;
            end
         end
         CBW_DONE: begin
            nxt_st.bstate = CBW_IDLE;
            nxt_st.dir_read = 1'b0;
         end
         default: begin
            nxt_st.bstate = CBW_IDLE;
         end
      endcase

      //----------------------------------------------------------------
      // Bus watch classification
      //----------------------------------------------------------------
      if (snoop.valid && snoop.hit) begin
         if (snoop.cycle_type[CT_WR]) begin
            if (watch_cpu && snoop.tag == TAG_PURGE) begin
               act = CBW_ACT_INVALIDATE;
            end else if (!snoop.cycle_type[CT_IO] && watch_cpu &&
                  snoop.tag == {1'b0, UTAG_SHARED_WT}) begin
               act = snoop.cycle_type[CT_QUAD] ? CBW_ACT_INVALIDATE :
                  CBW_ACT_UPDATE;
            end else if (snoop.cycle_type[CT_IO] && watch_io_wr &&
                  snoop.tag != {1'b0, UTAG_NONCACHE} && !snoop.tag[2]) begin
               act = snoop.cycle_type[CT_QUAD] ? CBW_ACT_INVALIDATE :
                  CBW_ACT_UPDATE;
            end
         end else if (snoop.cycle_type[CT_IO] && watch_io_rd &&
               snoop.tag == {1'b0, UTAG_PRIV_CB} && snoop.dirty) begin
            act = CBW_ACT_SUPPLY;
         end
      end
      nxt_st.cmd.act = act;
      nxt_st.cmd.clear_valid = act == CBW_ACT_SUPPLY &&
         st_ff.ctrl[CTL_CLEAR_VALID];
      nxt_st.inhibit = act == CBW_ACT_SUPPLY;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '{
            bstate: CBW_IDLE,
            cmd: '{act: CBW_ACT_NONE, clear_valid: 1'b0},
            sup_pdb: PDB_RESET,
            usr_pdb: PDB_RESET,
            ctrl: CTL_RESET,
            default: '0
         };
      end else begin
         st_ff <= nxt_st;
      end
   end

   //----------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------
   assign s_axi_awready = !st_ff.aw_hold;
   assign s_axi_wready = !st_ff.w_hold;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign cpu_busy = st_ff.bstate != CBW_IDLE;
   assign system_tag_lines = st_ff.tag;
   assign bus_request = st_ff.bstate == CBW_ADDR || st_ff.bstate == CBW_DATA;
   assign bus_write = st_ff.wr && bus_request;
   assign bus_dir_read = st_ff.dir_read;
   assign bus_data_oe = st_ff.data_oe;
   assign memory_inhibit = st_ff.inhibit;
   assign cache_cmd = st_ff.cmd;
   assign own_purge = st_ff.purge;
   assign prefetch_enable = st_ff.ctrl[CTL_PREFETCH] & !DATA_SIDE;
   assign flag_clear = st_ff.flag_clear;
   assign sup_pdb = st_ff.sup_pdb;
   assign usr_pdb = st_ff.usr_pdb;
endmodule // cbw_top
`default_nettype wire

//--- testbench/cbw_asserts.sv
/*
 Checker for cbw_top: snoop answers, own-cycle tagging, flag-clear pulse.
 Assumes the watch enables stay set whenever snoops are offered.
*/
`timescale 1ns/1ps
`default_nettype none
module cbw_asserts
   import cbw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Snoop side
   input wire cbw_snoop_type snoop,
   input wire cbw_cache_cmd_type cache_cmd,
   input wire logic memory_inhibit,
   // Own bus cycle
   input wire logic bus_request,
   input wire logic bus_write,
   input wire logic [2:0] system_tag_lines,
   input wire logic bus_data_oe,
   input wire logic bus_dir_read,
   input wire logic own_purge,
   input wire logic [6:0] flag_clear
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic hw = snoop.valid && snoop.hit && snoop.cycle_type[CT_WR];
   wire logic io = snoop.cycle_type[CT_IO];
   wire logic io_rd = snoop.valid && io && !snoop.cycle_type[CT_WR] && snoop.tag == 3'h2;
   wire logic slv_wr = bus_request && bus_write && system_tag_lines == TAG_SLAVE_IO;
   property p_purge_watch;
      hw && !io && snoop.tag == TAG_PURGE |=> cache_cmd.act == CBW_ACT_INVALIDATE;
   endproperty
   a_purge_watch: assert property (p_purge_watch) else $error("purge hit kept");
   property p_shared_wr;
      hw && !io && snoop.tag == 3'h1 |=> cache_cmd.act ==
         ($past(snoop.cycle_type[CT_QUAD]) ? CBW_ACT_INVALIDATE : CBW_ACT_UPDATE);
   endproperty
   a_shared_wr: assert property (p_shared_wr) else $error("shared write action wrong");
   property p_io_wr;
      hw && io && snoop.tag <= 3'h2 |=> cache_cmd.act ==
         ($past(snoop.cycle_type[CT_QUAD]) ? CBW_ACT_INVALIDATE : CBW_ACT_UPDATE);
   endproperty
   a_io_wr: assert property (p_io_wr) else $error("io write action wrong");
   property p_io_passive;
      io_rd && !(snoop.hit && snoop.dirty) |=> !memory_inhibit && cache_cmd.act == CBW_ACT_NONE;
   endproperty
   a_io_passive: assert property (p_io_passive) else $error("clean io read not passive");
   property p_io_supply;
      io_rd && snoop.hit && snoop.dirty |=> memory_inhibit && cache_cmd.act == CBW_ACT_SUPPLY;
   endproperty
   a_io_supply: assert property (p_io_supply) else $error("dirty io read not supplied");
   property p_clear_valid;
      cache_cmd.clear_valid |-> cache_cmd.act == CBW_ACT_SUPPLY && $past(io_rd) && $past(snoop.dirty);
   endproperty
   a_clear_valid: assert property (p_clear_valid) else $error("clear valid without supply");
   property p_own_purge;
      own_purge |-> bus_request && bus_write && system_tag_lines == TAG_PURGE;
   endproperty
   a_own_purge: assert property (p_own_purge) else $error("own purge off a purge write");
   property p_slave_oe;
      slv_wr |-> !bus_data_oe;
   endproperty
   a_slave_oe: assert property (p_slave_oe) else $error("data driven on slave write");
   property p_slave_dir;
      $rose(bus_request) && bus_write && system_tag_lines == TAG_SLAVE_IO |=> bus_dir_read;
   endproperty
   a_slave_dir: assert property (p_slave_dir) else $error("direction not read in data");
   property p_flag_pulse;
      flag_clear != 7'h00 |=> flag_clear == 7'h00 ##1 flag_clear == 7'h00;
   endproperty
   a_flag_pulse: assert property (p_flag_pulse) else $error("flag clear not one pulse");
endmodule // cbw_asserts
bind cbw_top cbw_asserts u_cbw_asserts (.clk, .rst_b, .snoop, .cache_cmd, .memory_inhibit,
   .bus_request, .bus_write, .system_tag_lines, .bus_data_oe, .bus_dir_read, .own_purge,
   .flag_clear);
`default_nettype wire

//--- testbench/cbw_bus_partner.sv
/*
 Far side of the system bus: memory or tag-7 I/O ending own cycles.
 Assumes bus_request stays high until ready has been seen.
*/
`timescale 1ns/1ps
`default_nettype none
module cbw_bus_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bus side
   input wire logic bus_request,
   input wire logic slow,
   output logic bus_ready_input
);
   int cnt;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         bus_ready_input <= 1'h0;
      end else if (!bus_request) begin
         cnt <= 0;
         bus_ready_input <= 1'h0;
      end else if (cnt >= (slow ? 6 : 1)) begin
         bus_ready_input <= 1'h1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // cbw_bus_partner
`default_nettype wire

//--- testbench/test_cache_bus_watch_control.sv
/*
 Self-checking bench for cbw_top: registers, snoop table, own bus cycles.
 Assumes the partner model ends own cycles with bus_ready_input.
*/
`timescale 1ns/1ps
`default_nettype none
module test_cache_bus_watch_control
   import cbw_pkg::*;
;
   logic clk = 1'h0, rst_b = 1'h0, slow = 1'h0, page_fault = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, fault_vaddr = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   cbw_cpu_req_type cpu_req = '0;
   cbw_snoop_type snoop = '0;
   cbw_cache_cmd_type cache_cmd;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_busy;
   logic bus_request, bus_write, bus_dir_read, bus_data_oe, bus_ready_input;
   logic memory_inhibit, own_purge, prefetch_enable;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] system_tag_lines, seen_tag = 3'h0;
   logic [6:0] flag_clear, seen_clr = 7'h00;
   logic [19:0] sup_pdb, usr_pdb;
   logic seen_oe = 1'h0, seen_dir = 1'h0, seen_purge = 1'h0;
   int fails = 0, tests_run = 0;
   // Snoop rows: tag, cycle type, hit and dirty, expected action, memory inhibit
   logic [13:0] rows [11] = '{
      {3'h6, 6'h10, 2'h2, 2'h2, 1'h0}, {3'h1, 6'h10, 2'h2, 2'h1, 1'h0},
      {3'h1, 6'h18, 2'h2, 2'h2, 1'h0}, {3'h1, 6'h10, 2'h0, 2'h0, 1'h0},
      {3'h0, 6'h30, 2'h2, 2'h1, 1'h0}, {3'h2, 6'h38, 2'h2, 2'h2, 1'h0},
      {3'h3, 6'h30, 2'h2, 2'h0, 1'h0}, {3'h2, 6'h20, 2'h1, 2'h0, 1'h0},
      {3'h2, 6'h28, 2'h2, 2'h0, 1'h0}, {3'h2, 6'h20, 2'h3, 2'h3, 1'h1},
      {3'h2, 6'h28, 2'h3, 2'h3, 1'h1}};

   cbw_top #(.DATA_SIDE(1'h1)) u_dut (
      .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cpu_req, .cpu_busy, .page_fault, .fault_vaddr, .system_tag_lines, .bus_request,
      .bus_write, .bus_dir_read, .bus_data_oe, .bus_ready_input, .snoop, .memory_inhibit,
      .cache_cmd, .own_purge, .prefetch_enable, .flag_clear, .sup_pdb, .usr_pdb);
   cbw_bus_partner u_partner (.clk, .rst_b, .bus_request, .slow, .bus_ready_input);

   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (bus_request) begin
         seen_tag <= system_tag_lines;
         seen_oe <= seen_oe | bus_data_oe;
         seen_dir <= seen_dir | bus_dir_read;
      end
      if (own_purge) seen_purge <= 1'h1;
      if (flag_clear != 7'h00) seen_clr <= flag_clear;
   end

   task automatic finish_test();
      if (fails == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic hang(input int n);
      if (n >= 50) begin
         fails++;
         finish_test();
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'h0;
      hang(n);
      chk(s_axi_bresp, er);
      @(posedge clk);
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'h0;
      hang(n);
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
      @(posedge clk);
   endtask

   // One own cycle: write, mapped, supervisor, page tag; expects tag and data drive
   task automatic own(input logic [5:0] f, input logic [31:0] a, input logic [3:0] e);
      int n;
      seen_oe = 1'h0;
      seen_dir = 1'h0;
      seen_purge = 1'h0;
      cpu_req <= {1'h1, f, a};
      @(posedge clk);
      cpu_req.valid <= 1'h0;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (!cpu_busy) break;
      end
      hang(n);
      chk({seen_tag, seen_oe}, e);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      for (int p = 0; p < 2; p++) begin
         if (p == 1) axi_wr(OFF_CTRL, 32'hFFFFFFFF, 2'h0);
         if (p == 1) axi_rd(OFF_CTRL, 32'h13F, 2'h0);
         foreach (rows[i]) begin
            snoop <= {1'h1, rows[i][13:3]};
            @(posedge clk);
            snoop.valid <= 1'h0;
            @(posedge clk);
            chk({cache_cmd, memory_inhibit}, {rows[i][2:1], p[0] & rows[i][0], rows[i][0]});
         end
         if (p == 0) chk(prefetch_enable, 1'h0);
         if (p == 0) axi_rd(OFF_CTRL, 32'h03F, 2'h0);
      end
      axi_rd(OFF_FLAG_CLR, 32'h0, 2'h0);
      axi_rd(OFF_SUP_PDB, 32'h0, 2'h0);
      axi_wr(OFF_SUP_PDB, 32'hFFFFFFFF, 2'h0);
      axi_rd(OFF_SUP_PDB, 32'h000FFFFF, 2'h0);
      chk(sup_pdb, 20'hFFFFF);
      s_axi_wstrb <= 4'h1;
      axi_wr(OFF_USR_PDB, 32'h12345678, 2'h0);
      s_axi_wstrb <= 4'hF;
      axi_rd(OFF_USR_PDB, 32'h00000078, 2'h0);
      chk(usr_pdb, 20'h00078);
      axi_rd(8'h14, 32'h0, 2'h2);
      axi_wr(OFF_FAULT, 32'h00001234, 2'h2);
      page_fault <= 1'h1;
      fault_vaddr <= 32'hCAFE1234;
      @(posedge clk);
      page_fault <= 1'h0;
      axi_rd(OFF_FAULT, 32'hCAFE1234, 2'h0);
      axi_wr(OFF_FLAG_CLR, 32'h55, 2'h0);
      chk(seen_clr, 7'h55);
      axi_wr(OFF_FLAG_CLR, 32'h2A, 2'h0);
      chk(seen_clr, 7'h2A);
      own({3'h6, 3'h6}, 32'h00020000, 4'hD);
      chk(seen_purge, 1'h1);
      own({3'h2, 3'h7}, 32'h00020000, 4'hE);
      slow <= 1'h1;
      own({3'h6, 3'h7}, 32'h00020000, 4'hE);
      chk(seen_dir, 1'h1);
      slow <= 1'h0;
      own({3'h1, 3'h5}, 32'h00007FFF, 4'hA);
      for (int u = 0; u < 4; u++) begin
         axi_wr(OFF_CTRL, {26'h0, u[1:0], 4'hF}, 2'h0);
         own({3'h0, 3'h5}, 32'h00010000, {1'h0, u[1:0], 1'h0});
      end
      finish_test();
   end
endmodule // test_cache_bus_watch_control
`default_nettype wire
